// File: fdc_regs.svh
// How it works
// - Late write byte: lost data, write zero
// - After data: two CRC bytes, FF, gate off
// - Read-ID passes six bytes with requests
// - Read-ID checks CRC, copies track, interrupts
// - Read-track streams index to index, no CRC
// - Read-track keeps read gate off
// - Write-track requests at once, records index-to-index
// - Empty holding register at index aborts
// - Missing track byte is written as zero
// - Write-track presets CRC on mark bytes
// - Single density clock patterns per byte
// - Double density F5/F6 special marks, F7 CRC
// - Force-interrupt ends command, enabled conditions interrupt
// - Zero conditions: end command, no interrupt
// - Immediate interrupt persists until later clear
// - New read-ID, read/write-track or write-sector command sets busy, loads not-ready from the pin, clears the rest (write commands also set request)
// - Force-interrupt clears busy, keeps or reclassifies flags
// - Status is eight flag bits
// - Read/write class status bit layout
`ifndef FDC_REGS_SVH
`define FDC_REGS_SVH
`define ADDR_COMMAND 8'h00
`define ADDR_STATUS 8'h04
`define ADDR_TRACK 8'h08
`define ADDR_SECTOR 8'h0c
`define ADDR_DATA 8'h10
`define ADDR_DRIVE 8'h14
`define ST_BUSY 0
`define ST_REQ 1
`define ST_LOST 2
`define ST_CRC 3
`define ST_MISSING 4
`define ST_FAULT 5
`define ST_PROT 6
`define ST_NRDY 7
`define STATUS_RESET 8'h00
`define CRC_PRESET 16'hffff
`define CMD_READ_ID 4'hc
`define CMD_READ_TRACK 4'he
`define CMD_WRITE_TRACK 4'hf
`define CMD_WRITE_SECTOR 4'ha
`define CMD_FORCE 4'hd
`define BYTE_CYCLES 8'd40
`endif

// File: fdc_pkg.sv
package fdc_pkg;
	// Encoded byte toward the write serialiser
	typedef struct packed {
		logic [7:0] data;
		logic [7:0] clock;
		logic [7:0] missing;
	} disk_byte_t;
	// Command classes
	typedef enum logic [1:0] {
		CLS_SEEK = 2'd0,
		CLS_READ = 2'd1,
		CLS_WRITE = 2'd2
	} cmd_class_t;
endpackage

// File: fdc_engine.sv
`timescale 1ns/1ps
`default_nettype none
`include "fdc_regs.svh"
module fdc_engine #(
	parameter int SECTOR_BYTES = 128
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic index_pin,
	input wire logic ready_pin,
	input wire logic density_select_input,
	input wire logic id_address_mark,
	input wire logic rd_strobe,
	input wire logic [7:0] rd_byte,
	input wire logic id_crc_ok,
	output fdc_pkg::disk_byte_t wr_byte,
	output logic wr_strobe,
	output logic write_gate_output,
	output logic read_gate_output,
	output logic crc_preset,
	output logic byte_request,
	output logic irq
);
	import fdc_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	logic [1:0] idx_s, rdy_s, dd_s;
	logic idx_d, rdy_d;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			idx_s <= 2'b00;
			rdy_s <= 2'b00;
			dd_s <= 2'b00;
			idx_d <= 1'b0;
			rdy_d <= 1'b0;
		end else begin
			idx_s <= {idx_s[0], index_pin};
			rdy_s <= {rdy_s[0], ready_pin};
			dd_s <= {dd_s[0], density_select_input};
			idx_d <= idx_s[1];
			rdy_d <= rdy_s[1];
		end
	end
	logic idx_rise, rdy_rise, rdy_fall, mfm;
	assign idx_rise = idx_s[1] & ~idx_d;
	assign rdy_rise = rdy_s[1] & ~rdy_d;
	assign rdy_fall = ~rdy_s[1] & rdy_d;
	assign mfm = ~dd_s[1];

	////////////////////////////////////////////////////////////////////////
	// APB decode
	logic acc, wr_acc, rd_acc;
	assign acc = psel & penable;
	assign wr_acc = acc & pwrite;
	assign rd_acc = acc & ~pwrite;
	logic cmd_wr, data_wr, data_rd, stat_rd;
	assign cmd_wr = wr_acc && paddr == `ADDR_COMMAND;
	assign data_wr = wr_acc && paddr == `ADDR_DATA;
	assign data_rd = rd_acc && paddr == `ADDR_DATA;
	assign stat_rd = rd_acc && paddr == `ADDR_STATUS;

	////////////////////////////////////////////////////////////////////////
	// State machine
	typedef enum logic [6:0] {
		S_IDLE = 7'b0000001,
		S_WAIT_IDX = 7'b0000010,
		S_TRACK = 7'b0000100,
		S_SEC_DATA = 7'b0001000,
		S_CRC1 = 7'b0010000,
		S_CRC2 = 7'b0100000,
		S_FF = 7'b1000000
	} state_t;
	state_t state;
	logic [7:0] status; // Status flags
	logic [7:0] data_reg; // Holding register
	logic [7:0] sector_reg; // Sector register
	logic [3:0] cmd; // Current opcode
	logic [3:0] force_cond; // Force-interrupt conditions
	logic imm_latch; // Immediate interrupt latched
	logic dr_full; // Holding register loaded: by the host on writes, by the disk on reads
	logic [7:0] slot_cnt; // Byte-time counter
	logic [2:0] id_cnt; // Read-ID byte index
	logic [10:0] byte_cnt; // Sector data index
	logic [1:0] crc_pend; // Pending CRC bytes for write-track
	logic slot;
	assign slot = slot_cnt == `BYTE_CYCLES - 8'd1;
	logic busy;
	assign busy = state != S_IDLE;

	// Byte slot timer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) slot_cnt <= 8'h00;
		else slot_cnt <= slot ? 8'h00 : slot_cnt + 8'd1;
	end

	// Write-track encoder for the holding register byte
	function automatic disk_byte_t encode(input logic [7:0] b, input logic dd);
		disk_byte_t e;
		e.data = b;
		e.clock = 8'hff;
		e.missing = 8'h00;
		if (dd) begin
			if (b == 8'hf5) begin // A1 with missing clock
				e.data = 8'ha1;
				e.missing = 8'h10;
			end else if (b == 8'hf6) begin // C2 with missing clock
				e.data = 8'hc2;
				e.missing = 8'h08;
			end
		end else if (b == 8'hfc) begin
			e.clock = 8'hd7;
		end else if (b >= 8'hf8 && b != 8'hfd && b != 8'hff) begin
			e.clock = 8'hc7;
		end
		return e;
	endfunction

	logic mark_preset;
	assign mark_preset = mfm ? (data_reg == 8'hf5) : (data_reg >= 8'hf8 && data_reg <= 8'hfe);

	// Command sequencing, status and disk output
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= S_IDLE;
			status <= `STATUS_RESET;
			cmd <= 4'h0;
			force_cond <= 4'h0;
			imm_latch <= 1'b0;
			irq <= 1'b0;
			dr_full <= 1'b0;
			byte_request <= 1'b0;
			data_reg <= 8'h00;
			sector_reg <= 8'h00;
			id_cnt <= 3'd0;
			byte_cnt <= 11'd0;
			crc_pend <= 2'd0;
			wr_byte <= '0;
			wr_strobe <= 1'b0;
			write_gate_output <= 1'b0;
			read_gate_output <= 1'b0;
			crc_preset <= 1'b0;
		end else begin
			wr_strobe <= 1'b0;
			crc_preset <= 1'b0;
			// Host data access clears the request
			if (data_wr) begin
				data_reg <= pwdata[7:0];
				dr_full <= 1'b1;
				byte_request <= 1'b0;
				status[`ST_REQ] <= 1'b0;
			end
			if (data_rd) begin
				dr_full <= 1'b0;
				byte_request <= 1'b0;
				status[`ST_REQ] <= 1'b0;
			end
			// Interrupt clear, only when the immediate latch allows
			if ((cmd_wr || stat_rd) && !imm_latch) irq <= 1'b0;
			else if ((cmd_wr || stat_rd) && imm_latch && cmd == `CMD_FORCE
				&& !(cmd_wr && pwdata[7:4] == `CMD_FORCE)) begin
				irq <= 1'b0;
				imm_latch <= 1'b0;
			end
			// Force-interrupt conditions while armed
			if (state == S_IDLE && cmd == `CMD_FORCE) begin
				if ((force_cond[0] && rdy_rise) || (force_cond[1] && rdy_fall)
					|| (force_cond[2] && idx_rise)) irq <= 1'b1;
			end
			if (cmd_wr && pwdata[7:4] == `CMD_FORCE) begin
				cmd <= `CMD_FORCE;
				force_cond <= pwdata[3:0];
				state <= S_IDLE; // Ends any command
				write_gate_output <= 1'b0;
				read_gate_output <= 1'b0;
				status[`ST_BUSY] <= 1'b0;
				if (!busy) status <= {~rdy_s[1], 6'h00, 1'b0}; // Seek-class meaning
				if (pwdata[3]) begin
					irq <= 1'b1;
					imm_latch <= 1'b1;
				end
			end else if (cmd_wr && !busy) begin
				cmd <= pwdata[7:4];
				status <= 8'h01; // Busy set, rest cleared
				status[`ST_NRDY] <= ~rdy_s[1];
				id_cnt <= 3'd0;
				byte_cnt <= 11'd0;
				crc_pend <= 2'd0;
				dr_full <= 1'b0;
				case (pwdata[7:4])
					`CMD_WRITE_TRACK: begin
						byte_request <= 1'b1; // Request at once
						status[`ST_REQ] <= 1'b1;
						state <= S_WAIT_IDX;
					end
					`CMD_READ_TRACK: state <= S_WAIT_IDX;
					`CMD_READ_ID: state <= S_WAIT_IDX;
					`CMD_WRITE_SECTOR: begin
						byte_request <= 1'b1;
						status[`ST_REQ] <= 1'b1;
						write_gate_output <= 1'b1;
						state <= S_SEC_DATA;
					end
					default: status <= 8'h00;
				endcase
			end else begin
				case (state)
					S_IDLE: begin
					end
					S_WAIT_IDX: begin
						if (cmd == `CMD_READ_ID) begin
							if (id_address_mark) state <= S_TRACK;
						end else if (idx_rise) begin
							if (cmd == `CMD_WRITE_TRACK && !dr_full) begin
								state <= S_IDLE; // Abort
								status[`ST_BUSY] <= 1'b0;
								status[`ST_LOST] <= 1'b1;
								irq <= 1'b1;
							end else begin
								state <= S_TRACK;
								write_gate_output <= cmd == `CMD_WRITE_TRACK;
								read_gate_output <= 1'b0;
							end
						end
					end
					S_TRACK: begin
						if (cmd == `CMD_WRITE_TRACK) begin
							if (idx_rise) begin
								state <= S_IDLE; // Ends at next index
								write_gate_output <= 1'b0;
								status[`ST_BUSY] <= 1'b0;
								irq <= 1'b1;
							end else if (slot) begin
								wr_strobe <= 1'b1;
								if (crc_pend != 2'd0) begin
									wr_byte <= '{data: 8'h00, clock: 8'hff, missing: 8'h00};
									crc_pend <= crc_pend - 2'd1; // Second CRC byte
								end else if (!dr_full) begin
									wr_byte <= '{data: 8'h00, clock: 8'hff, missing: 8'h00};
									status[`ST_LOST] <= 1'b1;
								end else if (data_reg == 8'hf7) begin
									wr_byte <= '{data: 8'h00, clock: 8'hff, missing: 8'h00};
									crc_pend <= 2'd1; // Two CRC bytes
								end else begin
									wr_byte <= encode(data_reg, mfm);
									crc_preset <= mark_preset;
								end
								if (crc_pend == 2'd0) begin
									dr_full <= 1'b0;
									byte_request <= 1'b1;
									status[`ST_REQ] <= 1'b1;
								end
							end
						end else if (cmd == `CMD_READ_TRACK) begin
							if (idx_rise) begin
								state <= S_IDLE;
								status[`ST_BUSY] <= 1'b0;
								irq <= 1'b1;
							end else if (rd_strobe) begin
								data_reg <= rd_byte; // Every byte, no CRC
								if (dr_full) status[`ST_LOST] <= 1'b1;
								dr_full <= 1'b1;
								byte_request <= 1'b1;
								status[`ST_REQ] <= 1'b1;
							end
						end else if (rd_strobe) begin
							data_reg <= rd_byte;
							if (dr_full) status[`ST_LOST] <= 1'b1;
							dr_full <= 1'b1;
							byte_request <= 1'b1;
							status[`ST_REQ] <= 1'b1;
							if (id_cnt == 3'd0) sector_reg <= rd_byte;
							id_cnt <= id_cnt + 3'd1;
							if (id_cnt == 3'd5) begin
								state <= S_IDLE;
								status[`ST_CRC] <= ~id_crc_ok;
								status[`ST_BUSY] <= 1'b0;
								irq <= 1'b1;
							end
						end
					end
					S_SEC_DATA: begin
						if (slot) begin
							wr_strobe <= 1'b1;
							if (dr_full) begin
								wr_byte <= '{data: data_reg, clock: 8'hff, missing: 8'h00};
							end else begin
								wr_byte <= '{data: 8'h00, clock: 8'hff, missing: 8'h00};
								status[`ST_LOST] <= 1'b1;
							end
							dr_full <= 1'b0;
							byte_cnt <= byte_cnt + 11'd1;
							if (byte_cnt == 11'(SECTOR_BYTES - 1)) begin
								state <= S_CRC1;
							end else begin
								byte_request <= 1'b1;
								status[`ST_REQ] <= 1'b1;
							end
						end
					end
					S_CRC1: if (slot) begin
						wr_strobe <= 1'b1; // CRC high byte
						wr_byte <= '{data: 8'h00, clock: 8'hff, missing: 8'h00};
						state <= S_CRC2;
					end
					S_CRC2: if (slot) begin
						wr_strobe <= 1'b1; // CRC low byte
						state <= S_FF;
					end
					S_FF: if (slot) begin
						// Gate stays on through the FF slot, drops one slot later
						if (crc_pend == 2'd0) begin
							wr_strobe <= 1'b1;
							wr_byte <= '{data: 8'hff, clock: 8'hff, missing: 8'h00};
							crc_pend <= 2'd1;
						end else begin
							state <= S_IDLE;
							write_gate_output <= 1'b0;
							status[`ST_BUSY] <= 1'b0;
							irq <= 1'b1;
						end
					end
					default: state <= S_IDLE;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// APB read port, one-cycle answer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel & ~penable;
			pslverr <= 1'b0;
			prdata <= 32'h0;
			if (psel && !penable && !pwrite) begin
				case (paddr)
					`ADDR_STATUS: prdata <= {24'h0, status};
					`ADDR_SECTOR: prdata <= {24'h0, sector_reg};
					`ADDR_DATA: prdata <= {24'h0, data_reg};
					`ADDR_COMMAND: prdata <= {28'h0, cmd};
					default: pslverr <= 1'b1;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	property p_busy_irq;
		@(posedge pclk) disable iff (!presetn)
		$fell(status[`ST_BUSY]) && !$past(cmd_wr) |-> irq;
	endproperty
	a_busy_irq: assert property (p_busy_irq) else $error("busy fell without irq");
	property p_rg_off;
		@(posedge pclk) disable iff (!presetn)
		cmd == `CMD_READ_TRACK |-> !read_gate_output;
	endproperty
	a_rg_off: assert property (p_rg_off) else $error("read gate on in track read");
	property p_wg_ff;
		@(posedge pclk) disable iff (!presetn)
		$fell(write_gate_output) && $past(state == S_FF) |-> wr_byte.data == 8'hff;
	endproperty
	a_wg_ff: assert property (p_wg_ff) else $error("gate off without FF");
	property p_req_clr;
		@(posedge pclk) disable iff (!presetn)
		data_wr && state != S_TRACK && state != S_SEC_DATA |=> !byte_request;
	endproperty
	a_req_clr: assert property (p_req_clr) else $error("request not cleared");
	property p_imm;
		@(posedge pclk) disable iff (!presetn)
		cmd_wr && pwdata[7:4] == `CMD_FORCE && pwdata[3] |=> irq ##1 irq;
	endproperty
	a_imm: assert property (p_imm) else $error("immediate irq lost");
	property p_force_busy;
		@(posedge pclk) disable iff (!presetn)
		cmd_wr && pwdata[7:4] == `CMD_FORCE |=> !status[`ST_BUSY] && state == S_IDLE;
	endproperty
	a_force_busy: assert property (p_force_busy) else $error("force left busy");
	property p_abort;
		@(posedge pclk) disable iff (!presetn)
		state == S_WAIT_IDX && cmd == `CMD_WRITE_TRACK && idx_rise && !dr_full && !cmd_wr
		|=> status[`ST_LOST] && irq && !write_gate_output;
	endproperty
	a_abort: assert property (p_abort) else $error("no abort on empty register");
	property p_new_busy;
		@(posedge pclk) disable iff (!presetn)
		cmd_wr && !busy && pwdata[7:4] == `CMD_READ_ID |=> status[`ST_BUSY] && !status[`ST_LOST];
	endproperty
	a_new_busy: assert property (p_new_busy) else $error("busy not set");
	c_wtrack: cover property (@(posedge pclk) state == S_TRACK && cmd == `CMD_WRITE_TRACK);
	c_rid: cover property (@(posedge pclk) cmd == `CMD_READ_ID && $fell(status[`ST_BUSY]));
	c_sec: cover property (@(posedge pclk) $fell(write_gate_output));
endmodule
`default_nettype wire

// File: disk_model.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////
// Drive-side model: index pulses and bytes read off the disk
module disk_model (
	input wire logic pclk,
	output logic index_pin,
	output logic id_address_mark,
	output logic rd_strobe,
	output logic [7:0] rd_byte
);
	// Idle levels before any traffic
	initial begin
		index_pin = 1'b0;
		id_address_mark = 1'b0;
		rd_strobe = 1'b0;
		rd_byte = 8'h5a;
	end
	// Index pulse, long enough to pass the input synchroniser
	task automatic idx();
		@(posedge pclk);
		index_pin <= 1'b1;
		repeat (10) @(posedge pclk);
		index_pin <= 1'b0;
	endtask
	// One disk byte; the first of a field is preceded by the mark
	task automatic put(input logic [7:0] b, input logic first);
		if (first) begin
			@(posedge pclk);
			id_address_mark <= 1'b1;
			repeat (3) @(posedge pclk);
			id_address_mark <= 1'b0;
		end
		@(posedge pclk);
		rd_strobe <= 1'b1;
		rd_byte <= b;
		@(posedge pclk);
		rd_strobe <= 1'b0;
		// Byte no longer valid: show its inverse
		rd_byte <= ~b;
	endtask
endmodule
`default_nettype wire

// File: floppy_track_command_engine_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "fdc_regs.svh"
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin error_cnt++; \
	$display("[ERR] t=%0t got %h exp %h", $time, (a), (b)); end end
module floppy_track_command_engine_bench;
	import fdc_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr;
	wire logic index_pin, id_address_mark, rd_strobe;
	wire logic [7:0] rd_byte;
	logic ready_pin = 1'b1;
	logic density_select_input = 1'b1;
	logic id_crc_ok = 1'b1;
	disk_byte_t wr_byte;
	logic wr_strobe, write_gate_output, read_gate_output, crc_preset, byte_request, irq;
	int error_cnt = 0;
	int comparisons = 0;
	int presets = 0;
	int seed = 64;
	logic [16:0] rq[$]; // Expected reads: error, mask, value
	logic [15:0] wq[$]; // Expected disk bytes: data, clock
	logic [7:0] id[6];
	logic [7:0] wdat; // Random write-sector byte
	// 20 MHz clock
	always #25 pclk = ~pclk;
	fdc_engine i_fdc_engine (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .index_pin(index_pin), .ready_pin(ready_pin),
		.density_select_input(density_select_input), .id_address_mark(id_address_mark),
		.rd_strobe(rd_strobe), .rd_byte(rd_byte), .id_crc_ok(id_crc_ok), .wr_byte(wr_byte),
		.wr_strobe(wr_strobe), .write_gate_output(write_gate_output),
		.read_gate_output(read_gate_output), .crc_preset(crc_preset),
		.byte_request(byte_request), .irq(irq));
	disk_model i_disk_model (.pclk(pclk), .index_pin(index_pin),
		.id_address_mark(id_address_mark), .rd_strobe(rd_strobe), .rd_byte(rd_byte));
	////////////////////////////////////////////////////////////////
	// Verdict and end of run
	task automatic summarize();
		`CHK(wq.size(), 0)
		$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// One APB transfer; reads note their expectation
	task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
		input logic [16:0] ex);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		penable <= 1'b0;
		@(posedge pclk);
		penable <= 1'b1;
		if (!w) rq.push_back(ex);
		for (k = 0; k < 50; k++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		psel <= 1'b0;
		penable <= 1'b0;
		if (k == 50) begin
			error_cnt++;
			summarize();
		end
	endtask
	// Bounded wait: 0 byte request, 1 interrupt, 2 disk byte strobe
	task automatic wait_on(input int sel);
		int k;
		for (k = 0; k < 8000; k++) begin
			@(posedge pclk);
			if ((sel == 0 ? byte_request : sel == 1 ? irq : wr_strobe) === 1'b1) break;
		end
		if (k == 8000) begin
			error_cnt++;
			summarize();
		end
	endtask
	////////////////////////////////////////////////////////////////
	// Read watcher: oldest note against the completed read
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1 && !pwrite) begin
			`CHK({pslverr, prdata[7:0] & rq[0][15:8]}, {rq[0][16], rq[0][7:0] & rq[0][15:8]})
			void'(rq.pop_front());
		end
	end
	// Disk byte watcher: recorded data and clock pattern
	always @(posedge pclk) begin
		if (crc_preset === 1'b1) presets++;
		if (wr_strobe === 1'b1 && wq.size() > 0) begin
			`CHK({wr_byte.data, wr_byte.clock}, wq[0])
			`CHK(write_gate_output, 1'b1)
			void'(wq.pop_front());
		end
	end
	////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		// Reset value and an unmapped address
		apb(0, `ADDR_STATUS, 0, {1'b0, 8'hff, `STATUS_RESET});
		apb(0, 8'h3c, 0, {1'b1, 8'h00, 8'h00});
		$display("test reset done");
		// Read-ID with a bad CRC and random field bytes
		for (int i = 0; i < 6; i++) id[i] = $random(seed);
		apb(1, `ADDR_COMMAND, 8'hc0, 0);
		apb(0, `ADDR_STATUS, 0, {1'b0, 8'h01, 8'h01});
		id_crc_ok <= 1'b0;
		for (int i = 0; i < 6; i++) begin
			i_disk_model.put(id[i], i == 0);
			wait_on(0);
			apb(0, `ADDR_DATA, 0, {1'b0, 8'hff, id[i]});
		end
		wait_on(1);
		apb(0, `ADDR_STATUS, 0, {1'b0, 8'h1f, 8'h08});
		apb(0, `ADDR_SECTOR, 0, {1'b0, 8'hff, id[0]});
		id_crc_ok <= 1'b1;
		$display("test read id done");
		// Write-track: request at once, mark byte, then a missed slot
		apb(1, `ADDR_COMMAND, 8'hf0, 0);
		apb(0, `ADDR_STATUS, 0, {1'b0, 8'h03, 8'h03});
		wait_on(0);
		apb(1, `ADDR_DATA, 8'hfe, 0);
		@(posedge pclk);
		`CHK(byte_request, 1'b0)
		wq.push_back({8'hfe, 8'hc7});
		wq.push_back({8'h00, 8'hff});
		i_disk_model.idx();
		repeat (120) @(posedge pclk);
		`CHK(presets, 1)
		// Zero conditions: stop without interrupt
		apb(1, `ADDR_COMMAND, 8'hd0, 0);
		repeat (4) @(posedge pclk);
		`CHK(irq, 1'b0)
		apb(0, `ADDR_STATUS, 0, {1'b0, 8'h01, 8'h00});
		$display("test write track done");
		// Double density: F5 becomes A1 and presets the CRC
		density_select_input <= 1'b0;
		apb(1, `ADDR_COMMAND, 8'hf0, 0);
		wait_on(0);
		apb(1, `ADDR_DATA, 8'hf5, 0);
		wq.push_back({8'ha1, 8'hff});
		i_disk_model.idx();
		repeat (120) @(posedge pclk);
		`CHK(presets, 2)
		apb(1, `ADDR_COMMAND, 8'hd0, 0);
		density_select_input <= 1'b1;
		$display("test double density done");
		// Write-track abort with an empty holding register
		apb(1, `ADDR_COMMAND, 8'hf0, 0);
		i_disk_model.idx();
		wait_on(1);
		apb(0, `ADDR_STATUS, 0, {1'b0, 8'h05, 8'h04});
		$display("test abort done");
		// Immediate interrupt stays until the status is read
		apb(1, `ADDR_COMMAND, 8'hd8, 0);
		repeat (20) @(posedge pclk);
		`CHK(irq, 1'b1)
		apb(0, `ADDR_STATUS, 0, {1'b0, 8'h01, 8'h00});
		repeat (4) @(posedge pclk);
		`CHK(irq, 1'b0)
		$display("test force done");
		// Every-index condition raises the interrupt
		apb(1, `ADDR_COMMAND, 8'hd4, 0);
		i_disk_model.idx();
		wait_on(1);
		apb(0, `ADDR_STATUS, 0, {1'b0, 8'h01, 8'h00});
		$display("test index condition done");
		// Write-sector: first slot missed, one random byte, then late host
		apb(1, `ADDR_COMMAND, 8'ha0, 0);
		wait_on(2);
		wdat = $random(seed);
		apb(1, `ADDR_DATA, wdat, 0);
		wq.push_back({wdat, 8'hff});
		repeat (128) wq.push_back({8'h00, 8'hff});
		wq.push_back({8'hff, 8'hff});
		wait_on(1);
		`CHK(write_gate_output, 1'b0)
		apb(0, `ADDR_STATUS, 0, {1'b0, 8'h05, 8'h04});
		$display("test write sector done");
		summarize();
	end
endmodule
`default_nettype wire
